// ### rtl/hpsr_pkg.sv
// ==========================================================
// host port strobe and request pins: shared constants
package hpsr_pkg;

  // ==========================================================
  // register map, byte addresses on the bus
  localparam int unsigned     ADDR_W     = 8;
  localparam logic [7:0]      OFF_CTRL   = 8'h00;
  localparam logic [7:0]      OFF_DDR    = 8'h04;
  localparam logic [7:0]      OFF_DATA   = 8'h08;
  localparam logic [7:0]      OFF_STAT   = 8'h0c;

  // ==========================================================
  // port control register fields
  localparam int unsigned     CTRL_W          = 16;
  localparam int unsigned     CTL_HOST_EN     = 0;
  localparam int unsigned     CTL_DUAL_STROBE = 1;
  localparam int unsigned     CTL_DUAL_REQ    = 2;
  localparam int unsigned     CTL_RD_POL      = 3;
  localparam int unsigned     CTL_DS_POL      = 4;
  localparam int unsigned     CTL_WR_POL      = 5;
  localparam int unsigned     CTL_REQ_POL     = 6;
  localparam int unsigned     CTL_RRQ_POL     = 7;
  localparam int unsigned     CTL_ACK_POL     = 8;
  localparam int unsigned     CTL_REQ_OD      = 9;
  localparam logic [15:0]     CTRL_RESET      = 16'h0000;
  localparam logic [15:0]     CTRL_MASK       = 16'h03ff;

  // ==========================================================
  // port b bit positions used by these pins
  localparam int unsigned     NPINS      = 4;
  localparam int unsigned     PB_BIT11   = 11;
  localparam int unsigned     PB_BIT12   = 12;
  localparam int unsigned     PB_BIT14   = 14;
  localparam int unsigned     PB_BIT15   = 15;
  localparam logic [15:0]     GPIO_MASK  = 16'hd800;
  localparam logic [15:0]     DDR_RESET  = 16'h0000;
  localparam logic [15:0]     DATA_RESET = 16'h0000;

  // ==========================================================
  // status register fields
  localparam int unsigned     ST_RW      = 0;
  localparam int unsigned     ST_RD      = 1;
  localparam int unsigned     ST_DS      = 2;
  localparam int unsigned     ST_WR      = 3;
  localparam int unsigned     ST_ACK     = 4;
  localparam int unsigned     ST_STOP    = 5;

  // ==========================================================
  // bus encodings
  localparam logic [1:0]      HTRANS_IDLE = 2'b00;
  localparam logic            HRESP_OKAY  = 1'b0;

  typedef enum logic {
    HPSR_SINGLE = 1'b0,
    HPSR_DUAL   = 1'b1
  } hpsr_style_e;

endpackage

// ### rtl/hpsr_sync.sv
`timescale 1ns/10ps
// ==========================================================
// two flop synchroniser for pad levels
module hpsr_sync #(
  parameter int unsigned W = 4
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // meta feeds only the second flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// ### rtl/hpsr_pin.sv
`timescale 1ns/10ps
// ==========================================================
// output side of one shared pad
module hpsr_pin (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // control
  input  wire logic drive,
  input  wire logic level,
  input  wire logic open_drain,
  input  wire logic freeze,
  // pad
  output logic      pad_o,
  output logic      pad_oe_n
);

  // reset leaves the pad an input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_o    <= 1'b0;
      pad_oe_n <= 1'b1;
    end else if (!freeze) begin
      if (drive && open_drain) begin
        pad_o    <= 1'b0;
        pad_oe_n <= level;
      end else if (drive) begin
        pad_o    <= level;
        pad_oe_n <= 1'b0;
      end else begin
        pad_o    <= 1'b0;
        pad_oe_n <= 1'b1;
      end
    end
  end

endmodule

// ### rtl/hpsr_top.sv
`timescale 1ns/10ps
module hpsr_top (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // core side
  input  wire logic        core_tx_request,
  input  wire logic        core_rx_request,
  input  wire logic        stop_mode,
  output logic             host_rw_dir_in,
  output logic             host_read_strobe_in,
  output logic             host_data_strobe_in,
  output logic             host_write_strobe_in,
  output logic             host_acknowledge_in,
  // pad b11
  input  wire logic        gpio_b_bit11_i,
  output logic             gpio_b_bit11_o,
  output logic             gpio_b_bit11_oe_n,
  // pad b12
  input  wire logic        gpio_b_bit12_i,
  output logic             gpio_b_bit12_o,
  output logic             gpio_b_bit12_oe_n,
  // pad b14
  input  wire logic        gpio_b_bit14_i,
  output logic             gpio_b_bit14_o,
  output logic             gpio_b_bit14_oe_n,
  // pad b15
  input  wire logic        gpio_b_bit15_i,
  output logic             gpio_b_bit15_o,
  output logic             gpio_b_bit15_oe_n
);

  // ==========================================================
  // declarations
  logic [15:0]                 ctrl;
  logic [15:0]                 ddr;
  logic [15:0]                 gpio_out;
  logic [15:0]                 gpio_in;
  logic [15:0]                 next_ctrl;
  logic [15:0]                 next_ddr;
  logic [15:0]                 next_gpio_out;
  logic [15:0]                 stat;
  logic                        wr_pend;
  logic [7:0]                  wr_addr;
  logic                        addr_valid;
  logic [7:0]                  rd_addr;
  logic [31:0]                 next_hrdata;
  logic [hpsr_pkg::NPINS-1:0]  pad_in;
  logic [hpsr_pkg::NPINS-1:0]  pad_sync;
  logic [hpsr_pkg::NPINS-1:0]  pin_drive;
  logic [hpsr_pkg::NPINS-1:0]  pin_level;
  logic [hpsr_pkg::NPINS-1:0]  pin_od;
  logic [hpsr_pkg::NPINS-1:0]  pad_o;
  logic [hpsr_pkg::NPINS-1:0]  pad_oe_n;
  logic                        host_en;
  hpsr_pkg::hpsr_style_e       strobe_style;
  hpsr_pkg::hpsr_style_e       req_style;
  logic                        s11;
  logic                        s12;
  logic                        s14;
  logic                        s15;
  logic                        single_req;
  logic                        tx_req_lvl;
  logic                        rx_req_lvl;
  logic                        next_rw;
  logic                        next_rd;
  logic                        next_ds;
  logic                        next_wr;
  logic                        next_ack;

  // ==========================================================
  // ahb-lite address phase
  // address and direction wait a cycle for the hwdata of the data phase
  assign addr_valid = hsel && hready && htrans[1];
  assign rd_addr    = haddr[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (hready) begin
      wr_pend <= addr_valid && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // zero wait state slave, always okay
  // no error response exists: unmapped offsets still answer okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= hpsr_pkg::HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= hpsr_pkg::HRESP_OKAY;
    end
  end

  // ==========================================================
  // register writes in the data phase
  always_comb begin
    next_ctrl     = ctrl;
    next_ddr      = ddr;
    next_gpio_out = gpio_out;
    if (wr_pend) begin
      unique case (wr_addr)
        hpsr_pkg::OFF_CTRL: next_ctrl = hwdata[15:0] & hpsr_pkg::CTRL_MASK;
        hpsr_pkg::OFF_DDR:  next_ddr = hwdata[15:0] & hpsr_pkg::GPIO_MASK;
        hpsr_pkg::OFF_DATA: next_gpio_out = hwdata[15:0] & hpsr_pkg::GPIO_MASK;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= hpsr_pkg::CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ddr      <= hpsr_pkg::DDR_RESET;
      gpio_out <= hpsr_pkg::DATA_RESET;
    end else begin
      ddr      <= next_ddr;
      gpio_out <= next_gpio_out;
    end
  end

  // ==========================================================
  // read data, taken from next values so a write just before is seen
  always_comb begin
    next_hrdata = 32'h0000_0000;
    unique case (rd_addr)
      hpsr_pkg::OFF_CTRL: next_hrdata = {16'h0000, next_ctrl};
      hpsr_pkg::OFF_DDR:  next_hrdata = {16'h0000, next_ddr};
      hpsr_pkg::OFF_DATA: next_hrdata = {16'h0000, next_gpio_out};
      hpsr_pkg::OFF_STAT: next_hrdata = {16'h0000, stat};
      default:            next_hrdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_valid && !hwrite) begin
      hrdata <= next_hrdata;
    end
  end

  // ==========================================================
  // status view of pad levels and decoded host inputs
  // stop shows here so software can tell why the pads froze
  always_comb begin
    stat                    = gpio_in;
    stat[hpsr_pkg::ST_RW]   = host_rw_dir_in;
    stat[hpsr_pkg::ST_RD]   = host_read_strobe_in;
    stat[hpsr_pkg::ST_DS]   = host_data_strobe_in;
    stat[hpsr_pkg::ST_WR]   = host_write_strobe_in;
    stat[hpsr_pkg::ST_ACK]  = host_acknowledge_in;
    stat[hpsr_pkg::ST_STOP] = stop_mode;
  end

  // ==========================================================
  // pad input synchronisers, schmitt levels arrive asynchronously
  assign pad_in = {gpio_b_bit15_i, gpio_b_bit14_i, gpio_b_bit12_i, gpio_b_bit11_i};

  hpsr_sync #(
    .W (hpsr_pkg::NPINS)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (pad_in),
    .q       (pad_sync)
  );

  assign s11 = pad_sync[0];
  assign s12 = pad_sync[1];
  assign s14 = pad_sync[2];
  assign s15 = pad_sync[3];

  // ==========================================================
  // mode decode
  // strobe and request styles are independent, so any mix is legal
  assign host_en      = ctrl[hpsr_pkg::CTL_HOST_EN];
  assign strobe_style = hpsr_pkg::hpsr_style_e'(ctrl[hpsr_pkg::CTL_DUAL_STROBE]);
  assign req_style    = hpsr_pkg::hpsr_style_e'(ctrl[hpsr_pkg::CTL_DUAL_REQ]);

  // ==========================================================
  // host strobe and ack inputs, polarity folded so inner logic sees active high; rw passes through unfolded
  always_comb begin
    next_rw  = 1'b0;
    next_rd  = 1'b0;
    next_ds  = 1'b0;
    next_wr  = 1'b0;
    next_ack = 1'b0;
    if (host_en) begin
      if (strobe_style == hpsr_pkg::HPSR_SINGLE) begin
        next_rw = s11;
        next_ds = s12 ^ ~ctrl[hpsr_pkg::CTL_DS_POL];
      end else begin
        next_rd = s11 ^ ~ctrl[hpsr_pkg::CTL_RD_POL];
        next_wr = s12 ^ ~ctrl[hpsr_pkg::CTL_WR_POL];
      end
      if (req_style == hpsr_pkg::HPSR_SINGLE) begin
        next_ack = s15 ^ ~ctrl[hpsr_pkg::CTL_ACK_POL];
      end
    end
  end

  // ==========================================================
  // stop freezes decoded inputs; wait is not decoded at all, so it cannot disturb pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      host_rw_dir_in       <= 1'b0;
      host_read_strobe_in  <= 1'b0;
      host_data_strobe_in  <= 1'b0;
      host_write_strobe_in <= 1'b0;
      host_acknowledge_in  <= 1'b0;
    end else if (!stop_mode) begin
      host_rw_dir_in       <= next_rw;
      host_read_strobe_in  <= next_rd;
      host_data_strobe_in  <= next_ds;
      host_write_strobe_in <= next_wr;
      host_acknowledge_in  <= next_ack;
    end
  end

  // ==========================================================
  // gpio input sampling, also ignored in stop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gpio_in <= 16'h0000;
    end else if (!stop_mode) begin
      gpio_in                    <= 16'h0000;
      gpio_in[hpsr_pkg::PB_BIT11] <= s11;
      gpio_in[hpsr_pkg::PB_BIT12] <= s12;
      gpio_in[hpsr_pkg::PB_BIT14] <= s14;
      gpio_in[hpsr_pkg::PB_BIT15] <= s15;
    end
  end

  // ==========================================================
  // request outputs toward the host
  // a clear polarity bit means active low, so an asserted request drives the pin low
  always_comb begin
    single_req = core_tx_request || core_rx_request;
    tx_req_lvl = 1'b1;
    unique case (req_style)
      hpsr_pkg::HPSR_SINGLE: begin
        tx_req_lvl = ~(single_req ^ ctrl[hpsr_pkg::CTL_REQ_POL]);
      end
      hpsr_pkg::HPSR_DUAL: begin
        tx_req_lvl = ~(core_tx_request ^ ctrl[hpsr_pkg::CTL_REQ_POL]);
      end
    endcase
    rx_req_lvl = ~(core_rx_request ^ ctrl[hpsr_pkg::CTL_RRQ_POL]);
  end

  // ==========================================================
  // per pad drive selection
  // in gpio function a request pad is a plain output or input as ddr selects, never open drain
  always_comb begin
    pin_drive = '0;
    pin_level = '0;
    pin_od    = '0;
    if (host_en) begin
      // strobe pads stay inputs in host function
      pin_drive[2] = 1'b1;
      pin_level[2] = tx_req_lvl;
      pin_od[2]    = ctrl[hpsr_pkg::CTL_REQ_OD];
      pin_drive[3] = (req_style == hpsr_pkg::HPSR_DUAL);
      pin_level[3] = rx_req_lvl;
      pin_od[3]    = ctrl[hpsr_pkg::CTL_REQ_OD];
    end else begin
      pin_drive[0] = ddr[hpsr_pkg::PB_BIT11];
      pin_drive[1] = ddr[hpsr_pkg::PB_BIT12];
      pin_drive[2] = ddr[hpsr_pkg::PB_BIT14];
      pin_drive[3] = ddr[hpsr_pkg::PB_BIT15];
      pin_level[0] = gpio_out[hpsr_pkg::PB_BIT11];
      pin_level[1] = gpio_out[hpsr_pkg::PB_BIT12];
      pin_level[2] = gpio_out[hpsr_pkg::PB_BIT14];
      pin_level[3] = gpio_out[hpsr_pkg::PB_BIT15];
    end
  end

  // ==========================================================
  // output pad cells; stop holds the last drive, standing in for the keepers
  // holding the flops gives the pin the level a keeper would keep
  for (genvar i = 0; i < hpsr_pkg::NPINS; i++) begin : g_pin
    hpsr_pin u_pin (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .drive      (pin_drive[i]),
      .level      (pin_level[i]),
      .open_drain (pin_od[i]),
      .freeze     (stop_mode),
      .pad_o      (pad_o[i]),
      .pad_oe_n   (pad_oe_n[i])
    );
  end

  assign gpio_b_bit11_o    = pad_o[0];
  assign gpio_b_bit11_oe_n = pad_oe_n[0];
  assign gpio_b_bit12_o    = pad_o[1];
  assign gpio_b_bit12_oe_n = pad_oe_n[1];
  assign gpio_b_bit14_o    = pad_o[2];
  assign gpio_b_bit14_oe_n = pad_oe_n[2];
  assign gpio_b_bit15_o    = pad_o[3];
  assign gpio_b_bit15_oe_n = pad_oe_n[3];

endmodule

// ### rtl/_unused_placeholder_removed.sv
`timescale 1ns/10ps

// ### sim/hpsr_host.sv
`timescale 1ns/10ps
// ==========
// host bus side: resolves each shared line from both drivers
module hpsr_host (
  // device pads
  input  wire logic [3:0] dev_o,
  input  wire logic [3:0] dev_oe_n,
  // host drivers
  input  wire logic [3:0] host_en,
  input  wire logic [3:0] host_lv,
  // resolved lines
  output logic      [3:0] pin
);
  // board pull-ups: a released open-drain request reads high, never a stale level
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!dev_oe_n[i]) begin
        pin[i] = dev_o[i];
      end else if (host_en[i]) begin
        pin[i] = host_lv[i];
      end else begin
        pin[i] = 1'b1;
      end
    end
  end
endmodule

// ### sim/hpsr_top_properties.sv
`timescale 1ns/10ps
// ==========
// checker on the pins and bus of the top
module hpsr_top_properties (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // core side
  input wire logic        core_tx_request,
  input wire logic        core_rx_request,
  input wire logic        stop_mode,
  input wire logic        host_rw_dir_in,
  input wire logic        host_read_strobe_in,
  input wire logic        host_data_strobe_in,
  input wire logic        host_write_strobe_in,
  input wire logic        host_acknowledge_in,
  // pads
  input wire logic        gpio_b_bit11_i,
  input wire logic        gpio_b_bit11_o,
  input wire logic        gpio_b_bit11_oe_n,
  input wire logic        gpio_b_bit12_i,
  input wire logic        gpio_b_bit12_o,
  input wire logic        gpio_b_bit12_oe_n,
  input wire logic        gpio_b_bit14_o,
  input wire logic        gpio_b_bit14_oe_n,
  input wire logic        gpio_b_bit15_i,
  input wire logic        gpio_b_bit15_o,
  input wire logic        gpio_b_bit15_oe_n
);
  // ==========
  // register shadow kept from bus writes
  logic [15:0] cq;
  logic [15:0] dq;
  logic [15:0] oq;
  logic        wp;
  logic [7:0]  wa;
  logic [2:0]  run;
  logic        lv;
  wire         hen = cq[0];
  wire         dst = cq[1];
  wire         drq = cq[2];
  wire         rq  = drq ? core_tx_request : core_tx_request | core_rx_request;
  wire         l14 = hen ? rq ~^ cq[6] : oq[14];
  wire         l15 = hen ? core_rx_request ~^ cq[7] : oq[15];
  wire         z14 = hen ? cq[9] & l14 : !dq[14];
  wire         z15 = hen ? !drq | (cq[9] & l15) : !dq[15];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp <= 1'b0;
      wa <= 8'h00;
      lv <= 1'b0;
    end else begin
      wp <= hsel & hready & htrans[1] & hwrite;
      wa <= haddr[7:0];
      lv <= !stop_mode;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cq <= hpsr_pkg::CTRL_RESET;
      dq <= hpsr_pkg::DDR_RESET;
      oq <= hpsr_pkg::DATA_RESET;
    end else if (wp) begin
      if (wa == hpsr_pkg::OFF_CTRL) cq <= hwdata[15:0] & hpsr_pkg::CTRL_MASK;
      if (wa == hpsr_pkg::OFF_DDR) dq <= hwdata[15:0] & hpsr_pkg::GPIO_MASK;
      if (wa == hpsr_pkg::OFF_DATA) oq <= hwdata[15:0] & hpsr_pkg::GPIO_MASK;
    end
  end

  // decoded inputs lag pads by three edges, so demand four clean edges first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run <= 3'h0;
    end else if (stop_mode || (wp && wa == hpsr_pkg::OFF_CTRL)) begin
      run <= 3'h0;
    end else if (run != 3'h7) begin
      run <= run + 3'h1;
    end
  end

  // ==========
  // properties
  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_in;
    run > 3'h3 |-> {host_rw_dir_in, host_acknowledge_in} == {hen & !dst &
      $past(gpio_b_bit11_i, 3), hen & !drq & ($past(gpio_b_bit15_i, 3) ~^ cq[8])};
  endproperty
  a_in: assert property (p_in) else $error("rw or ack level wrong");
  property p_strb;
    run > 3'h3 |-> {host_read_strobe_in, host_data_strobe_in, host_write_strobe_in} ==
      {hen & dst & ($past(gpio_b_bit11_i, 3) ~^ cq[3]),
       hen & !dst & ($past(gpio_b_bit12_i, 3) ~^ cq[4]),
       hen & dst & ($past(gpio_b_bit12_i, 3) ~^ cq[5])};
  endproperty
  a_strb: assert property (p_strb) else $error("strobe wrong");
  property p_p11;
    lv |-> gpio_b_bit11_oe_n == $past(hen | !dq[11]) &&
      (gpio_b_bit11_oe_n || gpio_b_bit11_o == $past(oq[11]));
  endproperty
  a_p11: assert property (p_p11) else $error("pad 11 wrong");
  property p_p12;
    lv |-> gpio_b_bit12_oe_n == $past(hen | !dq[12]) &&
      (gpio_b_bit12_oe_n || gpio_b_bit12_o == $past(oq[12]));
  endproperty
  a_p12: assert property (p_p12) else $error("pad 12 wrong");
  property p_p14;
    lv |-> gpio_b_bit14_oe_n == $past(z14) && (gpio_b_bit14_oe_n || gpio_b_bit14_o == $past(l14));
  endproperty
  a_p14: assert property (p_p14) else $error("request wrong");
  property p_p15;
    lv |-> gpio_b_bit15_oe_n == $past(z15) && (gpio_b_bit15_oe_n || gpio_b_bit15_o == $past(l15));
  endproperty
  a_p15: assert property (p_p15) else $error("rx request wrong");
  property p_keep;
    $past(hresetn) && $past(stop_mode) |-> $stable({gpio_b_bit11_o, gpio_b_bit11_oe_n,
      gpio_b_bit12_o, gpio_b_bit12_oe_n, gpio_b_bit14_o, gpio_b_bit14_oe_n,
      gpio_b_bit15_o, gpio_b_bit15_oe_n});
  endproperty
  a_keep: assert property (p_keep) else $error("pad moved in stop");
  property p_ign;
    $past(hresetn) && $past(stop_mode) |-> $stable({host_rw_dir_in, host_read_strobe_in,
      host_data_strobe_in, host_write_strobe_in, host_acknowledge_in});
  endproperty
  a_ign: assert property (p_ign) else $error("input seen in stop");
  property p_bus;
    hreadyout && hresp == hpsr_pkg::HRESP_OKAY;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer not ready or not okay");
endmodule

bind hpsr_top hpsr_top_properties chk (.*);

// ### sim/hpsr_top_tb.sv
`timescale 1ns/10ps
module hpsr_top_tb;
  // ==========
  // stimulus state
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        tx = 1'b0;
  logic        rx = 1'b0;
  logic        stop = 1'b0;
  logic [4:0]  dec;
  logic [3:0]  po;
  logic [3:0]  poe;
  logic [3:0]  pin;
  logic [3:0]  hen = 4'h0;
  logic [3:0]  hl = 4'h0;
  logic [31:0] seed = 32'h0001427b;
  int          bad_count = 0;
  int          n_checks = 0;
  int          cyc = 0;

  always #2 hclk = ~hclk;

  hpsr_top dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .core_tx_request(tx), .core_rx_request(rx),
    .stop_mode(stop), .host_rw_dir_in(dec[0]), .host_read_strobe_in(dec[1]),
    .host_data_strobe_in(dec[2]), .host_write_strobe_in(dec[3]),
    .host_acknowledge_in(dec[4]),
    .gpio_b_bit11_i(pin[0]), .gpio_b_bit11_o(po[0]), .gpio_b_bit11_oe_n(poe[0]),
    .gpio_b_bit12_i(pin[1]), .gpio_b_bit12_o(po[1]), .gpio_b_bit12_oe_n(poe[1]),
    .gpio_b_bit14_i(pin[2]), .gpio_b_bit14_o(po[2]), .gpio_b_bit14_oe_n(poe[2]),
    .gpio_b_bit15_i(pin[3]), .gpio_b_bit15_o(po[3]), .gpio_b_bit15_oe_n(poe[3])
  );

  hpsr_host host (.dev_o(po), .dev_oe_n(poe), .host_en(hen), .host_lv(hl), .pin(pin));

  // ==========
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // bit order {ack, wr, ds, rd, rw}; p is what the host puts on the lines
  function automatic logic [4:0] exp_dec(input logic [15:0] c, input logic [3:0] p);
    exp_dec = {c[0] & !c[2] & (p[3] ~^ c[8]), c[0] & c[1] & (p[1] ~^ c[5]),
               c[0] & !c[1] & (p[1] ~^ c[4]), c[0] & c[1] & (p[0] ~^ c[3]),
               c[0] & !c[1] & p[0]};
  endfunction

  // {oe_n b15, oe_n b14, line b15, line b14} in host function
  function automatic logic [3:0] exp_req(input logic [15:0] c, input logic t, input logic r,
                                         input logic hb);
    logic a;
    logic b;
    a = (c[2] ? t : t | r) ~^ c[6];
    b = r ~^ c[7];
    exp_req = {c[2] ? c[9] & b : 1'b1, c[9] & a, c[2] ? b : hb, a};
  endfunction

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= hpsr_pkg::HTRANS_IDLE;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic chk_reg(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      bad_count++;
      $display("unexpected at %0t: read %h, wanted %h", $time, g, x);
    end
  endtask

  task automatic chk_pin(input logic [7:0] g, input logic [7:0] x);
    n_checks++;
    if (g !== x) begin
      bad_count++;
      $display("unexpected at %0t: pins %b, wanted %b", $time, g, x);
    end
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // a hang costs one mismatch and still reaches the report
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      $display("unexpected at %0t: run did not finish", $time);
      summarize();
    end
  end

  // ==========
  // tests
  initial begin
    logic [31:0] r;
    logic [31:0] d;
    logic [15:0] c;
    logic [3:0]  e;
    logic [3:0]  g;
    logic [7:0]  sp;
    logic [4:0]  sd;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b1, 8'h10, 32'hffffffff, r);
    bus(1'b0, hpsr_pkg::OFF_CTRL, 32'h0, r);
    chk_reg(r, {16'h0, hpsr_pkg::CTRL_RESET});
    bus(1'b0, hpsr_pkg::OFF_DDR, 32'h0, r);
    chk_reg(r, {16'h0, hpsr_pkg::DDR_RESET});
    bus(1'b0, 8'h10, 32'h0, r);
    chk_reg(r, 32'h0);
    chk_pin({4'h0, poe}, 8'h0f);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      c = r[15:0] & hpsr_pkg::GPIO_MASK;
      e = {c[15], c[14], c[12], c[11]};
      hl <= r[19:16];
      hen <= ~e;
      d = rnd();
      bus(1'b1, hpsr_pkg::OFF_DDR, {16'h0, c}, r);
      bus(1'b1, hpsr_pkg::OFF_DATA, d, r);
      repeat (5) @(posedge hclk);
      g = (e & {d[15], d[14], d[12], d[11]}) | (~e & hl);
      chk_pin({poe, pin}, {~e, g});
      bus(1'b0, hpsr_pkg::OFF_STAT, 32'h0, r);
      chk_reg(r, {16'h0, g[3], g[2], 1'b0, g[1], g[0], 11'h0});
    end
    $display("test gpio done");
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      c = (r[15:0] & 16'h01f8) | {6'h0, i[2], 6'h0, i[1], i[0], 1'b1};
      tx <= r[16];
      rx <= r[17];
      hl <= r[21:18];
      hen <= i[1] ? 4'h3 : 4'hb;
      bus(1'b1, hpsr_pkg::OFF_CTRL, {16'h0, c}, r);
      repeat (5) @(posedge hclk);
      e = exp_req(c, tx, rx, hl[3]);
      sp = {e[3:2], 2'b11, e[1:0], hl[1:0]};
      sd = exp_dec(c, hl);
      chk_pin({poe, pin}, sp);
      chk_pin({3'h0, dec}, {3'h0, sd});
      bus(1'b0, hpsr_pkg::OFF_CTRL, 32'h0, r);
      chk_reg(r, {16'h0, c});
    end
    $display("test host done");
    stop <= 1'b1;
    repeat (2) @(posedge hclk);
    sp = {poe, po};
    sd = dec;
    tx <= ~tx;
    rx <= ~rx;
    hl <= ~hl;
    repeat (6) @(posedge hclk);
    chk_pin({poe, po}, sp);
    chk_pin({3'h0, dec}, {3'h0, sd});
    stop <= 1'b0;
    repeat (2) @(posedge hclk);
    $display("test stop done");
    summarize();
  end
endmodule
